// ### radio_ctrl_pkg.sv
// shared constants and carrier types for the radio state command and auto-ack config block
`default_nettype none
package radio_ctrl_pkg;
	// register addresses on the serial register port
	localparam int ADDR_W = 6;
	localparam logic [5:0] ADDR_STATUS = 6'h01;
	localparam logic [5:0] ADDR_CMD = 6'h02;
	localparam logic [5:0] ADDR_CTRL1 = 6'h04;
	localparam logic [5:0] ADDR_XAH1 = 6'h17;
	// state command codes
	localparam logic [4:0] CMD_NOP = 5'h00;
	localparam logic [4:0] CMD_TX_START = 5'h02;
	localparam logic [4:0] CMD_FORCE_OFF = 5'h03;
	localparam logic [4:0] CMD_FORCE_PLL_ON = 5'h04;
	localparam logic [4:0] CMD_RX_ON = 5'h06;
	localparam logic [4:0] CMD_IDLE_CLOCK = 5'h08;
	localparam logic [4:0] CMD_PLL_ON = 5'h09;
	localparam logic [4:0] CMD_AUTO_ACK_LISTEN = 5'h16;
	localparam logic [4:0] CMD_AUTO_RETRY_SEND = 5'h19;
	// transceiver state codes as reported in the current state field
	localparam logic [4:0] ST_P_ON = 5'h00;
	localparam logic [4:0] ST_BUSY_TX = 5'h02;
	localparam logic [4:0] ST_RX_ON = 5'h06;
	localparam logic [4:0] ST_OFF = 5'h08;
	localparam logic [4:0] ST_PLL_ON = 5'h09;
	localparam logic [4:0] ST_SLEEP = 5'h0f;
	localparam logic [4:0] ST_BUSY_TX_RETRY = 5'h12;
	localparam logic [4:0] ST_AUTO_ACK = 5'h16;
	localparam logic [4:0] ST_AUTO_RETRY = 5'h19;
	localparam logic [4:0] ST_TRANSITION = 5'h1f;
	// field positions
	localparam int CTRL1_AUTO_FCS = 5;
	localparam int CTRL1_EXT_RX_START = 6;
	localparam int XAH_SEND_TS = 7;
	localparam int XAH_RES_FILTER = 5;
	localparam int XAH_RES_UPLOAD = 4;
	localparam int XAH_ACK_TIME = 2;
	localparam int XAH_PROMISC = 1;
	// writable bits and reset values
	localparam logic [7:0] CTRL1_MASK = 8'h7f;
	localparam logic [7:0] XAH_MASK = 8'hb6;
	localparam logic [7:0] CTRL1_RST = 8'h22;
	localparam logic [7:0] XAH_RST = 8'h00;
	localparam logic [4:0] CMD_RST = 5'h00;
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int SYMBOL_NS = 16000;
	localparam int SYMBOL_CYC = (SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACK_LONG_SYM = 12;
	localparam int ACK_SHORT_SYM = 2;
	localparam int TMR_W = 12;
	localparam logic [11:0] TX_DELAY_CYC = 12'(SYMBOL_CYC);
	localparam logic [11:0] ACK_LONG_CYC = 12'(ACK_LONG_SYM * SYMBOL_CYC);
	localparam logic [11:0] ACK_SHORT_CYC = 12'(ACK_SHORT_SYM * SYMBOL_CYC);
	// one register access from the serial port
	typedef struct packed {
		logic wr;
		logic [5:0] addr;
		logic [7:0] wdata;
	} reg_access_type;
	// per-frame information from the receive path
	typedef struct packed {
		logic frame_end;
		logic hdr_valid;
		logic fcs_ok;
		logic addr_match;
		logic reserved_type;
		logic data_or_cmd;
		logic ack_req;
	} rx_info_type;
endpackage
`default_nettype wire

// ### radio_state_cmd_and_aack_cfg.sv
// state command decode, transmit checksum enable and auto-ack configuration of the radio
// Summary of operation
// - a command field write starts the matching state transition where the current state allows it
// - decode nop, send start, forced off, forced synth on, listen, idle, synth on
// - codes 0x16 and 0x19 enter auto-ack listen and auto-retry send modes
// - command field reads zero after reset
// - frame sending starts one symbol period after the send start command
// - forced synth on is ignored in power-on, sleep or transition states
// - control register bit 5 enables automatic transmit checksum; resets to one
// - automatic checksum works in basic and extended modes alike
// - time-stamp bit pulses aux output on every auto-retry transmission; resets zero
// - unfiltered reserved frames are checked only for a valid checksum
// - filtered reserved frames get the same address filtering as data frames
// - uploaded reserved frames with good checksum that pass the filter raise the frame complete event
// - uploaded reserved frames raise address match when addresses match
// - accepted reserved frames requesting ack are acknowledged unless ack suppressed
// - ack turnaround bit zero sends ack twelve symbols after frame end
// - ack turnaround bit one sends ack two symbols after frame end
// - promiscuous mode ends every valid-header frame with complete event and fcs flag
`timescale 1ns/1ps
`default_nettype none
module radio_state_cmd_and_aack_cfg (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_spi_sclk,
	input wire logic i_spi_mosi,
	input wire logic i_spi_sel_n,
	input wire logic i_tx_done,
	input wire radio_ctrl_pkg::rx_info_type i_rx,
	input wire logic i_ack_suppress,
	output logic o_spi_miso,
	output logic o_spi_miso_oe_n,
	output logic [4:0] o_current_state,
	output logic o_auto_fcs_enable,
	output logic o_ext_rx_start_indication_enable,
	output logic o_tx_start,
	output logic o_aux_digital_output,
	output logic o_frame_complete_event,
	output logic o_address_match_event,
	output logic o_rx_fcs_valid,
	output logic o_ack_send
);
	typedef struct packed {
		logic [4:0] cmd;
		logic [4:0] trx;
		logic [7:0] ctrl1;
		logic [7:0] xah;
		logic tx_start;
		logic aux;
		logic complete;
		logic address_match_event;
		logic fcs_valid;
		logic ack_send;
	} ctrl_state_type;
	ctrl_state_type st_ff;
	ctrl_state_type nxt_st;
	radio_ctrl_pkg::reg_access_type acc;
	logic [7:0] rd_data;
	logic cmd_wr;
	logic [4:0] code;
	logic tx_load;
	logic tx_cancel;
	logic tx_expire;
	logic ack_load;
	logic ack_expire;
	logic [11:0] ack_cycles;
	logic filt_ok;
	logic accept;
	logic aack_frame;

	// register port on the serial pins
	spi_reg_port u_port (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_spi_sclk(i_spi_sclk),
		.i_spi_mosi(i_spi_mosi),
		.i_spi_sel_n(i_spi_sel_n),
		.i_rd_data(rd_data),
		.o_acc(acc),
		.o_miso(o_spi_miso),
		.o_miso_oe_n(o_spi_miso_oe_n)
	);

	// one-symbol wait between send start and the frame going out
	symbol_delay #(.CNT_W(radio_ctrl_pkg::TMR_W)) u_tx_delay (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_load(tx_load),
		.i_cancel(tx_cancel),
		.i_cycles(radio_ctrl_pkg::TX_DELAY_CYC),
		.o_expire(tx_expire)
	);

	// acknowledgement turnaround wait
	symbol_delay #(.CNT_W(radio_ctrl_pkg::TMR_W)) u_ack_delay (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_load(ack_load),
		.i_cancel(1'b0),
		.i_cycles(ack_cycles),
		.o_expire(ack_expire)
	);

	// read mux; reserved bits are masked off so they always read zero
	always_comb begin
		unique case (acc.addr)
			radio_ctrl_pkg::ADDR_STATUS: rd_data = {3'h0, st_ff.trx};
			radio_ctrl_pkg::ADDR_CMD: rd_data = {3'h0, st_ff.cmd};
			radio_ctrl_pkg::ADDR_CTRL1: rd_data = st_ff.ctrl1 & radio_ctrl_pkg::CTRL1_MASK;
			radio_ctrl_pkg::ADDR_XAH1: rd_data = st_ff.xah & radio_ctrl_pkg::XAH_MASK;
			default: rd_data = 8'h00;
		endcase
	end

	assign cmd_wr = acc.wr && (acc.addr == radio_ctrl_pkg::ADDR_CMD);
	assign code = acc.wdata[4:0];

	// next-state logic for commands, transmit sequencing and frame ends
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tx_start = 1'b0;
		nxt_st.aux = 1'b0;
		nxt_st.complete = 1'b0;
		nxt_st.address_match_event = 1'b0;
		nxt_st.ack_send = 1'b0;
		tx_load = 1'b0;
		tx_cancel = 1'b0;
		ack_load = 1'b0;
		filt_ok = 1'b0;
		accept = 1'b0;
		aack_frame = 1'b0;
		// turnaround chosen when the frame ends, later bit changes do not move it
		ack_cycles = st_ff.xah[radio_ctrl_pkg::XAH_ACK_TIME] ?
			radio_ctrl_pkg::ACK_SHORT_CYC : radio_ctrl_pkg::ACK_LONG_CYC;
		// control register writes; reserved bits never stored
		if (acc.wr && acc.addr == radio_ctrl_pkg::ADDR_CTRL1) begin
			nxt_st.ctrl1 = acc.wdata & radio_ctrl_pkg::CTRL1_MASK;
		end
		if (acc.wr && acc.addr == radio_ctrl_pkg::ADDR_XAH1) begin
			nxt_st.xah = acc.wdata & radio_ctrl_pkg::XAH_MASK;
		end
		// end of a transmission returns to the mode it was sent from
		if (i_tx_done) begin
			if (st_ff.trx == radio_ctrl_pkg::ST_BUSY_TX) begin
				nxt_st.trx = radio_ctrl_pkg::ST_PLL_ON;
			end else if (st_ff.trx == radio_ctrl_pkg::ST_BUSY_TX_RETRY) begin
				nxt_st.trx = radio_ctrl_pkg::ST_AUTO_RETRY;
			end
		end
		// state commands; a state-changing command overrides a coincident tx done, nop and send start leave it
		if (cmd_wr) begin
			nxt_st.cmd = code;
			case (code)
				radio_ctrl_pkg::CMD_TX_START: begin
					// send start only means something where the synthesizer is locked
					if (st_ff.trx == radio_ctrl_pkg::ST_PLL_ON ||
						st_ff.trx == radio_ctrl_pkg::ST_AUTO_RETRY) begin
						tx_load = 1'b1;
					end
				end
				radio_ctrl_pkg::CMD_FORCE_OFF: begin
					nxt_st.trx = radio_ctrl_pkg::ST_OFF;
					tx_cancel = 1'b1;
				end
				radio_ctrl_pkg::CMD_FORCE_PLL_ON: begin
					if (st_ff.trx != radio_ctrl_pkg::ST_P_ON &&
						st_ff.trx != radio_ctrl_pkg::ST_SLEEP &&
						st_ff.trx != radio_ctrl_pkg::ST_TRANSITION) begin
						nxt_st.trx = radio_ctrl_pkg::ST_PLL_ON;
						tx_cancel = 1'b1;
					end
				end
				radio_ctrl_pkg::CMD_RX_ON: begin
					nxt_st.trx = radio_ctrl_pkg::ST_RX_ON;
					tx_cancel = 1'b1;
				end
				radio_ctrl_pkg::CMD_IDLE_CLOCK: begin
					nxt_st.trx = radio_ctrl_pkg::ST_OFF;
					tx_cancel = 1'b1;
				end
				radio_ctrl_pkg::CMD_PLL_ON: begin
					nxt_st.trx = radio_ctrl_pkg::ST_PLL_ON;
					tx_cancel = 1'b1;
				end
				radio_ctrl_pkg::CMD_AUTO_ACK_LISTEN: begin
					nxt_st.trx = radio_ctrl_pkg::ST_AUTO_ACK;
					tx_cancel = 1'b1;
				end
				radio_ctrl_pkg::CMD_AUTO_RETRY_SEND: begin
					nxt_st.trx = radio_ctrl_pkg::ST_AUTO_RETRY;
					tx_cancel = 1'b1;
				end
				default: begin
					// nop and reserved codes keep the current state
				end
			endcase
		end
		// a state change in the same cycle as expiry wins and drops the send
		if (tx_expire && !tx_cancel) begin
			nxt_st.tx_start = 1'b1;
			if (st_ff.trx == radio_ctrl_pkg::ST_AUTO_RETRY) begin
				nxt_st.trx = radio_ctrl_pkg::ST_BUSY_TX_RETRY;
				nxt_st.aux = st_ff.xah[radio_ctrl_pkg::XAH_SEND_TS];
			end else begin
				nxt_st.trx = radio_ctrl_pkg::ST_BUSY_TX;
			end
		end
		// receive decisions only apply while listening in auto-ack mode
		aack_frame = i_rx.frame_end && i_rx.hdr_valid &&
			st_ff.trx == radio_ctrl_pkg::ST_AUTO_ACK;
		if (i_rx.reserved_type) begin
			filt_ok = st_ff.xah[radio_ctrl_pkg::XAH_RES_FILTER] ?
				i_rx.addr_match : 1'b1;
			accept = st_ff.xah[radio_ctrl_pkg::XAH_RES_UPLOAD] &&
				i_rx.fcs_ok && filt_ok;
		end else begin
			filt_ok = i_rx.addr_match;
			accept = i_rx.fcs_ok && filt_ok;
		end
		if (aack_frame) begin
			nxt_st.fcs_valid = i_rx.fcs_ok;
			nxt_st.complete = accept || st_ff.xah[radio_ctrl_pkg::XAH_PROMISC];
			nxt_st.address_match_event = i_rx.addr_match && (!i_rx.reserved_type ||
				st_ff.xah[radio_ctrl_pkg::XAH_RES_UPLOAD]);
			// no ack for frames that fail the filter, even in promiscuous mode
			ack_load = accept && i_rx.ack_req && !i_ack_suppress &&
				(i_rx.data_or_cmd || i_rx.reserved_type);
		end
		if (ack_expire) begin
			nxt_st.ack_send = 1'b1;
		end
	end

	// state register; command field clears to the no-operation code
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_ff <= '{cmd: radio_ctrl_pkg::CMD_RST, trx: radio_ctrl_pkg::ST_P_ON,
				ctrl1: radio_ctrl_pkg::CTRL1_RST, xah: radio_ctrl_pkg::XAH_RST,
				default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_current_state = st_ff.trx;
	// checksum enable holds in every operating mode
	assign o_auto_fcs_enable = st_ff.ctrl1[radio_ctrl_pkg::CTRL1_AUTO_FCS];
	assign o_ext_rx_start_indication_enable = st_ff.ctrl1[radio_ctrl_pkg::CTRL1_EXT_RX_START];
	assign o_tx_start = st_ff.tx_start;
	assign o_aux_digital_output = st_ff.aux;
	assign o_frame_complete_event = st_ff.complete;
	assign o_address_match_event = st_ff.address_match_event;
	assign o_rx_fcs_valid = st_ff.fcs_valid;
	assign o_ack_send = st_ff.ack_send;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_cmd_store:
	assert property (cmd_wr |=> st_ff.cmd == $past(code)) else $error("command field not stored");
	a_rx_on_cmd:
	assert property (cmd_wr && code == radio_ctrl_pkg::CMD_RX_ON && !tx_expire
		|=> o_current_state == radio_ctrl_pkg::ST_RX_ON) else $error("listen command ignored");
	a_aack_cmd:
	assert property (cmd_wr && code == radio_ctrl_pkg::CMD_AUTO_ACK_LISTEN
		|=> o_current_state == radio_ctrl_pkg::ST_AUTO_ACK) else $error("auto-ack not entered");
	a_cmd_reset:
	assert property ($rose(i_rst_n) |-> st_ff.cmd == 5'h00 && o_auto_fcs_enable)
		else $error("bad reset value");
	a_tx_delay:
	assert property (o_tx_start |-> $past(tx_load, 161)) else $error("send not one symbol late");
	a_force_block:
	assert property (cmd_wr && code == radio_ctrl_pkg::CMD_FORCE_PLL_ON &&
		(st_ff.trx == radio_ctrl_pkg::ST_P_ON || st_ff.trx == radio_ctrl_pkg::ST_SLEEP)
		|=> $stable(o_current_state)) else $error("forced synth on took effect");
	a_auto_fcs:
	assert property (acc.wr && acc.addr == radio_ctrl_pkg::ADDR_CTRL1
		|=> o_auto_fcs_enable == $past(acc.wdata[5])) else $error("checksum enable not written");
	a_ts_pulse:
	assert property (o_aux_digital_output |-> o_tx_start && st_ff.xah[7] &&
		o_current_state == radio_ctrl_pkg::ST_BUSY_TX_RETRY) else $error("stray time-stamp");
	a_resv_nofilt:
	assert property (aack_frame && i_rx.reserved_type && st_ff.xah[4] && !st_ff.xah[5] &&
		i_rx.fcs_ok |=> o_frame_complete_event) else $error("reserved frame dropped");
	a_upload_off:
	assert property (aack_frame && i_rx.reserved_type && !st_ff.xah[4] && !st_ff.xah[1]
		|=> !o_frame_complete_event) else $error("reserved frame not dropped");
	a_ack_short:
	assert property (ack_load && st_ff.xah[2] |-> ##[321:321] o_ack_send)
		else $error("short ack turnaround wrong");
	a_promisc_end:
	assert property (aack_frame && st_ff.xah[1] |=> o_frame_complete_event &&
		o_rx_fcs_valid == $past(i_rx.fcs_ok)) else $error("promiscuous frame end missing");
	a_resv_code:
	assert property (cmd_wr && code > radio_ctrl_pkg::CMD_PLL_ON &&
		code != radio_ctrl_pkg::CMD_AUTO_ACK_LISTEN &&
		code != radio_ctrl_pkg::CMD_AUTO_RETRY_SEND && !tx_expire && !i_tx_done
		|=> $stable(o_current_state)) else $error("reserved code changed state");
	a_resv_bits:
	assert property (acc.addr == radio_ctrl_pkg::ADDR_XAH1 |-> rd_data[6] == 1'b0 &&
		rd_data[3] == 1'b0 && rd_data[0] == 1'b0) else $error("reserved bit reads one");
endmodule
`default_nettype wire

// ### spi_host_model.sv
// host side model of the serial register port, mode 0, one register per select
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire logic i_ref_clk,
	input wire logic i_miso,
	output logic o_sclk,
	output logic o_mosi,
	output logic o_sel_n
);
	// half period in reference clocks, above the three the port needs to see each level
	localparam int HALF = 5;
	// idle bus: clock low, not selected
	initial begin
		o_sclk = 1'b0;
		o_mosi = 1'b0;
		o_sel_n = 1'b1;
	end
	// command byte then data byte, msb first; read data is taken on each clock rise
	task automatic xfer(input logic wr, input logic [5:0] addr, input logic [7:0] wdata,
		output logic [7:0] rdata);
		logic [15:0] sh;
		sh = {1'b1, wr, addr, wdata};
		rdata = 8'h00;
		@(negedge i_ref_clk) o_sel_n = 1'b0;
		repeat (4) @(negedge i_ref_clk);
		for (int i = 15; i >= 0; i--) begin
			o_mosi = sh[i];
			repeat (HALF) @(negedge i_ref_clk);
			o_sclk = 1'b1;
			rdata = {rdata[6:0], i_miso};
			repeat (HALF) @(negedge i_ref_clk);
			o_sclk = 1'b0;
		end
		// released data line flips so a stale bit never looks like a drive
		o_mosi = ~o_mosi;
		o_sel_n = 1'b1;
		repeat (4) @(negedge i_ref_clk);
	endtask
endmodule
`default_nettype wire

// ### spi_reg_port.sv
// serial register port slave: command byte then one data byte per select
`timescale 1ns/1ps
`default_nettype none
module spi_reg_port (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_spi_sclk,
	input wire logic i_spi_mosi,
	input wire logic i_spi_sel_n,
	input wire logic [7:0] i_rd_data,
	output radio_ctrl_pkg::reg_access_type o_acc,
	output logic o_miso,
	output logic o_miso_oe_n
);
	typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA, PH_DONE} phase_type;
	typedef struct packed {
		logic sclk_m;
		logic sclk_s;
		logic sclk_p;
		logic mosi_m;
		logic mosi_s;
		logic sel_m;
		logic sel_s;
		phase_type phase;
		logic [2:0] bits;
		logic [7:0] shin;
		logic [7:0] shout;
		logic load;
		logic wr_req;
		radio_ctrl_pkg::reg_access_type acc;
		logic miso;
		logic miso_oe_n;
	} spi_state_type;
	spi_state_type st_ff;
	spi_state_type nxt_st;
	logic rise;
	logic fall;
	logic [7:0] byte_in;
	phase_type ph;

	// pins pass two flops before any edge detection reads them
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sclk_m = i_spi_sclk;
		nxt_st.sclk_s = st_ff.sclk_m;
		nxt_st.sclk_p = st_ff.sclk_s;
		nxt_st.mosi_m = i_spi_mosi;
		nxt_st.mosi_s = st_ff.mosi_m;
		nxt_st.sel_m = i_spi_sel_n;
		nxt_st.sel_s = st_ff.sel_m;
		nxt_st.acc.wr = 1'b0;
		nxt_st.load = 1'b0;
		rise = st_ff.sclk_s & ~st_ff.sclk_p;
		fall = ~st_ff.sclk_s & st_ff.sclk_p;
		byte_in = {st_ff.shin[6:0], st_ff.mosi_s};
		ph = (st_ff.phase == PH_IDLE) ? PH_CMD : st_ff.phase;
		if (st_ff.sel_s) begin
			nxt_st.phase = PH_IDLE;
			nxt_st.bits = 3'h0;
			nxt_st.shout = 8'h00;
			nxt_st.miso = 1'b0;
			nxt_st.miso_oe_n = 1'b1;
		end else begin
			nxt_st.miso_oe_n = 1'b0;
			nxt_st.phase = ph;
			// read data is fetched one cycle after the address byte closes
			if (st_ff.load) begin
				nxt_st.shout = i_rd_data;
			end
			if (rise) begin
				nxt_st.shin = byte_in;
				nxt_st.bits = st_ff.bits + 3'h1;
				if (st_ff.bits == 3'h7) begin
					unique case (ph)
						PH_CMD: begin
							nxt_st.acc.addr = byte_in[5:0];
							nxt_st.wr_req = byte_in[6];
							nxt_st.load = ~byte_in[6];
							nxt_st.phase = byte_in[7] ? PH_DATA : PH_DONE;
						end
						PH_DATA: begin
							nxt_st.acc.wr = st_ff.wr_req;
							nxt_st.acc.wdata = byte_in;
							nxt_st.phase = PH_DONE;
						end
						PH_IDLE, PH_DONE: begin
						end
					endcase
				end
			end
			if (fall) begin
				nxt_st.miso = st_ff.shout[7];
				nxt_st.shout = {st_ff.shout[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_ff <= '{phase: PH_IDLE, miso_oe_n: 1'b1, sel_m: 1'b1, sel_s: 1'b1, default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_acc = st_ff.acc;
	assign o_miso = st_ff.miso;
	assign o_miso_oe_n = st_ff.miso_oe_n;
endmodule
`default_nettype wire

// ### symbol_delay.sv
// down-counter that flags the cycle in which a loaded delay runs out
`timescale 1ns/1ps
`default_nettype none
module symbol_delay #(
	parameter int CNT_W = 12
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_load,
	input wire logic i_cancel,
	input wire logic [CNT_W-1:0] i_cycles,
	output logic o_expire
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} delay_state_type;
	delay_state_type st_ff;
	delay_state_type nxt_st;

	// load wins over cancel so a fresh start is never lost
	always_comb begin
		nxt_st = st_ff;
		if (i_load) begin
			nxt_st.cnt = i_cycles;
		end else if (i_cancel) begin
			nxt_st.cnt = '0;
		end else if (st_ff.cnt != '0) begin
			nxt_st.cnt = st_ff.cnt - CNT_W'(1);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// expiry is seen i_cycles minus one edges after the load edge
	assign o_expire = (st_ff.cnt == CNT_W'(1));
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the radio state command and auto-ack config block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_ref_clk, i_rst_n, i_spi_sclk, i_spi_mosi, i_spi_sel_n, i_tx_done, i_ack_suppress;
	radio_ctrl_pkg::rx_info_type i_rx;
	logic o_spi_miso, o_spi_miso_oe_n, o_auto_fcs_enable, o_ext_rx_start_indication_enable;
	logic o_tx_start, o_aux_digital_output, o_frame_complete_event, o_address_match_event;
	logic o_rx_fcs_valid, o_ack_send, tx_aux;
	logic miso_line;
	logic [4:0] o_current_state;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	int rise_cyc = 0;
	int tx_gap = 0;
	logic [4:0] codes [9] = '{5'h08, 5'h06, 5'h04, 5'h03, 5'h09, 5'h16, 5'h19, 5'h00, 5'h1e};
	logic [4:0] exps [9] = '{5'h08, 5'h06, 5'h09, 5'h08, 5'h09, 5'h16, 5'h19, 5'h19, 5'h19};
	// free-running reference clock
	initial begin
		i_ref_clk = 1'b0;
		forever #50 i_ref_clk = ~i_ref_clk;
	end
	// an undriven data-out line shows the inverse, so a late enable corrupts the read
	assign miso_line = o_spi_miso_oe_n ? ~o_spi_miso : o_spi_miso;
	spi_host_model u_host (.i_ref_clk(i_ref_clk), .i_miso(miso_line), .o_sclk(i_spi_sclk),
		.o_mosi(i_spi_mosi), .o_sel_n(i_spi_sel_n));
	radio_state_cmd_and_aack_cfg u_dut (.i_ref_clk, .i_rst_n, .i_spi_sclk, .i_spi_mosi,
		.i_spi_sel_n, .i_tx_done, .i_rx, .i_ack_suppress, .o_spi_miso, .o_spi_miso_oe_n,
		.o_current_state, .o_auto_fcs_enable, .o_ext_rx_start_indication_enable, .o_tx_start,
		.o_aux_digital_output, .o_frame_complete_event, .o_address_match_event, .o_rx_fcs_valid,
		.o_ack_send);
	// send start is timed from the last serial clock rise, since the write pulse is internal
	always @(posedge i_spi_sclk) rise_cyc = cyc;
	// cycles counted on the rise; the one-cycle send pulse is looked at mid-cycle
	always @(posedge i_ref_clk) cyc++;
	always @(negedge i_ref_clk) begin
		if (o_tx_start === 1'b1) begin
			tx_gap = cyc - rise_cyc;
			tx_aux = o_aux_digital_output;
		end
	end
	// comparison tasks, one per kind of result
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp, input string what);
		cmp8({7'h00, got}, {7'h00, exp}, what);
	endtask
	task automatic cmpn(input int got, input int exp, input string what);
		checks_done++;
		if (got != exp) begin
			err_count++;
			$display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask
	// register access through the host model
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] x;
		u_host.xfer(1'b1, a, d, x);
	endtask
	task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string what);
		logic [7:0] x;
		u_host.xfer(1'b0, a, 8'h00, x);
		cmp8(x, e, what);
	endtask
	// state command, then the host polls status before issuing anything else
	task automatic cmd(input logic [4:0] c, input logic [4:0] e);
		wr(6'h02, {3'h0, c});
		rdc(6'h01, {3'h0, e}, "status");
		cmp8({3'h0, o_current_state}, {3'h0, e}, "state out");
	endtask
	// one send start from state c with the time-stamp bit ts
	task automatic send(input logic [4:0] c, input logic ts, input logic ea);
		int k;
		wr(6'h04, {1'b0, ts, 6'h20});
		wr(6'h17, {ts, 7'h00});
		cmd(c, c);
		cmp1(o_auto_fcs_enable, 1'b1, "auto fcs");
		cmp1(o_ext_rx_start_indication_enable, ts, "ext indication");
		tx_gap = 0;
		wr(6'h02, 8'h02);
		k = 0;
		while (k < 400 && tx_gap == 0) begin
			@(negedge i_ref_clk);
			k++;
		end
		cmpn(int'(tx_gap >= radio_ctrl_pkg::SYMBOL_CYC + 2 &&
			tx_gap <= radio_ctrl_pkg::SYMBOL_CYC + 8), 1, "send delay");
		cmp1(tx_aux, ea, "time stamp");
		@(negedge i_ref_clk) i_tx_done = 1'b1;
		@(negedge i_ref_clk) i_tx_done = 1'b0;
		cmd(5'h00, c);
	endtask
	// one received frame in auto-ack listen; e = {complete, match, fcs valid, ack}
	task automatic frame(input logic [7:0] xah, input logic [6:0] f, input logic sup,
		input logic [3:0] e);
		int k;
		wr(6'h17, xah);
		i_ack_suppress = sup;
		@(negedge i_ref_clk) i_rx = f;
		@(negedge i_ref_clk) i_rx = '0;
		cmp1(o_frame_complete_event, e[3], "complete");
		cmp1(o_address_match_event, e[2], "addr match");
		cmp1(o_rx_fcs_valid, e[1], "fcs valid");
		k = 1;
		while (k < 2000 && o_ack_send !== 1'b1) begin
			@(negedge i_ref_clk);
			k++;
		end
		cmpn(k, e[0] ? radio_ctrl_pkg::SYMBOL_CYC * (xah[2] ? 2 : 12) + 1 : 2000, "ack");
		$display("test frame %h done", f);
	endtask
	// prints the counts and the verdict, then ends the run
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// watchdog, about four times the expected run
	initial begin
		repeat (100000) @(posedge i_ref_clk);
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end
	// main sequence
	initial begin
		i_rst_n = 1'b0;
		i_tx_done = 1'b0;
		i_ack_suppress = 1'b0;
		i_rx = '0;
		repeat (16) @(negedge i_ref_clk);
		i_rst_n = 1'b1;
		cmp1(o_auto_fcs_enable, 1'b1, "fcs reset");
		cmp1(o_spi_miso_oe_n, 1'b1, "miso released");
		rdc(6'h02, 8'h00, "cmd reset");
		rdc(6'h04, 8'h22, "ctrl reset");
		rdc(6'h17, 8'h00, "xah reset");
		rdc(6'h3e, 8'h00, "unmapped");
		wr(6'h04, 8'hff);
		rdc(6'h04, 8'h7f, "ctrl mask");
		wr(6'h04, 8'h00);
		cmp1(o_auto_fcs_enable, 1'b0, "fcs off");
		wr(6'h17, 8'hff);
		rdc(6'h17, 8'hb6, "xah mask");
		$display("test registers done");
		cmd(5'h04, 5'h00);
		cmd(5'h05, 5'h00);
		for (int i = 0; i < 9; i++) cmd(codes[i], exps[i]);
		rdc(6'h02, 8'h1e, "cmd readback");
		$display("test commands done");
		// reset again mid-run: command field and state return to their reset values
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_ref_clk);
		i_rst_n = 1'b1;
		rdc(6'h02, 8'h00, "cmd after reset");
		rdc(6'h01, 8'h00, "state after reset");
		$display("test reset done");
		cmd(5'h08, 5'h08);
		tx_gap = 0;
		wr(6'h02, 8'h02);
		repeat (300) @(negedge i_ref_clk);
		cmpn(tx_gap, 0, "send from off");
		send(5'h09, 1'b1, 1'b0);
		send(5'h19, 1'b0, 1'b0);
		send(5'h19, 1'b1, 1'b1);
		$display("test send done");
		cmd(5'h16, 5'h16);
		frame(8'h00, 7'h7b, 1'b0, 4'hf);
		frame(8'h04, 7'h7b, 1'b0, 4'hf);
		frame(8'h04, 7'h7d, 1'b0, 4'h2);
		frame(8'h14, 7'h75, 1'b0, 4'hb);
		frame(8'h34, 7'h75, 1'b0, 4'h2);
		frame(8'h14, 7'h7d, 1'b1, 4'he);
		frame(8'h02, 7'h63, 1'b0, 4'h8);
		summarize();
	end
endmodule
`default_nettype wire
